// ===== rtl/uart_rx_status_regs.svh
// register offsets, field positions, reset values and timing for the rx status block
`ifndef UART_RX_STATUS_REGS_SVH
`define UART_RX_STATUS_REGS_SVH
`define OFS_STATUS        4'h0
`define OFS_DATA          4'h1
`define OFS_CTRL_ONE      4'h2
`define OFS_CTRL_TWO      4'h3
`define OFS_CTRL_THREE    4'h4
`define OFS_BAUD          4'h5
`define OFS_INTCTRL       4'h6
`define OFS_WAKEINFO      4'h7
// status bits
`define ST_PERR           0
`define ST_FERR           1
`define ST_OERR           2
`define ST_RXIF           3
`define ST_TXIF           4
`define ST_TIDLE          5
// control one bits
`define C1_MODE           7
`define C1_ENABLE         6
`define C1_NINE           5
`define C1_PREN           4
`define C1_PODD           3
`define C1_RX8            0
// control three bits
`define C3_TWOSTOP        0
// control two bits
`define C2_TXEN           7
`define C2_RXEN           6
`define C2_ADDEN          4
`define C2_WAKE           3
`define C2_RIE            2
`define C2_TIIE           1
`define C2_TEIE           0
// interrupt control bits
`define IC_GLOBAL         0
`define IC_SIM            1
`define CTRL_RESET        8'h00
`define BAUD_RESET        8'h00
// system start-up time after pin wake-up
`define STARTUP_NS        1024000
`define STARTUP_CYCLES    ((`STARTUP_NS + 24) / 25)
`endif

// ===== rtl/uart_rx_status_pkg.sv
// types shared by the rx status block
package uart_rx_status_pkg;
	typedef enum logic [1:0] {
		run_st,
		sleep_st,
		startup_st
	} power_t;
endpackage

// ===== rtl/uart_rx_status.sv
// uart receive status, interrupt combine, address detect and wake-up logic
// Notes on behaviour
// - stop bit sampled low sets read-only framing error flag
// - with two stop bits, either stop position low sets framing error
// - framing flag stored with received word; cleared by any reset
// - parity mismatch sets parity error flag only when checking enabled
// - parity flag kept with matching word; cleared by any reset
// - six sources merge into one low-pulse serial interrupt request
// - transmit sources own enables; rx data and overrun share one
// - address detect raises interrupt, no flag, only when enabled
// - clock off plus wake conditions: pin falling edge raises wake-up
// - status flags read-only, cleared only by defined uart actions
// - module interrupt enable masks the combined request
// - address detect on: data interrupt only if top word bit high
// - address detect off: data interrupt on every data-available set
// - clock stopped freezes all uart activity until it returns; here only rx, overrun and tx events stop, register access and wake-up run on
// - registers keep contents through idle or sleep
// - after pin wake-up, data ignored until start-up time elapses
// - wake interrupt needs global and module enables, after start-up
// - error flags clear by status access then data buffer read
// - nine-bit select stores received top bit in control one
`timescale 1ns/10ps
`default_nettype none
`include "uart_rx_status_regs.svh"

module uart_rx_status
	import uart_rx_status_pkg::*;
#(
	parameter int STARTUP_CYCLES = `STARTUP_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        rst,
	// avalon-mm slave
	input  wire logic [3:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output var  logic [31:0] readdata,
	output var  logic        waitrequest,
	// from the receive shifter
	input  wire logic        rx_word_valid,
	input  wire logic [8:0]  rx_word,
	input  wire logic        rx_stop1_bit,
	input  wire logic        rx_stop2_bit,
	input  wire logic        rx_parity_bit,
	input  wire logic        rx_overrun,
	// from transmitter
	input  wire logic        tx_empty_event,
	input  wire logic        tx_idle_event,
	// clock gating and pin
	input  wire logic        uart_clock_off,
	input  wire logic        serial_rx_tx_pin,
	// outputs
	output var  logic        sim_irq_n,
	output var  logic        wake_request,
	output var  logic        rx_ignore
);
	// start-up count must fit the 24-bit counter
	if (STARTUP_CYCLES < 1 || STARTUP_CYCLES > 32'h00FFFFFF) begin : g_bad_startup
		$error("STARTUP_CYCLES out of range");
	end

	typedef struct packed {
		logic [31:0] readdata;
		logic        waitrequest;
		logic [7:0]  ctrl1;
		logic [7:0]  ctrl2;
		logic [7:0]  ctrl3;
		logic [7:0]  baud;
		logic [1:0]  intctrl;
		logic [8:0]  data;
		logic        perr;
		logic        ferr;
		logic        oerr;
		logic        rxif;
		logic        txif;
		logic        tidle;
		logic        status_seen;
		logic        pin_prev;
		power_t      power;
		logic [23:0] cnt;
		logic        wake_pend;
		logic        irq_n;
		logic        wake_req;
		logic        ignore;
	} state_t;

	state_t s, n;
	logic   active, stop_bad, par_bad, top_bit, data_ev, addr_ev;
	logic   wake_ok, fall, rd, wr, data_rd, stat_acc;

	// combinational next state
	always_comb begin
		n = s;
		active = !uart_clock_off && s.power != sleep_st;
		n.waitrequest = !s.waitrequest ? 1'b1 : !(read || write);
		rd = read && !s.waitrequest;
		wr = write && !s.waitrequest;
		stat_acc = (rd || wr) && address == `OFS_STATUS;
		data_rd = rd && address == `OFS_DATA;
		// stop-bit checks, second only with two stop bits
		stop_bad = !rx_stop1_bit ||
			(s.ctrl3[`C3_TWOSTOP] && !rx_stop2_bit);
		par_bad = s.ctrl1[`C1_PREN] && (^{rx_word[8] & s.ctrl1[`C1_NINE],
			rx_word[7:0], rx_parity_bit} != s.ctrl1[`C1_PODD]);
		top_bit = s.ctrl1[`C1_NINE] ? rx_word[8] : rx_word[7];
		data_ev = rx_word_valid && active && !s.ignore;
		addr_ev = data_ev && s.ctrl2[`C2_ADDEN] && top_bit;
		n.readdata = s.readdata;
		// load read data as waitrequest drops, so it stands at acceptance
		if (read && s.waitrequest) begin
			case (address)
			`OFS_STATUS: n.readdata = {26'h0, s.tidle, s.txif, s.rxif,
				s.oerr, s.ferr, s.perr};
			`OFS_DATA: n.readdata = {23'h0, s.data};
			`OFS_CTRL_ONE: n.readdata = {24'h0, s.ctrl1};
			`OFS_CTRL_TWO: n.readdata = {24'h0, s.ctrl2};
			`OFS_CTRL_THREE: n.readdata = {24'h0, s.ctrl3};
			`OFS_BAUD: n.readdata = {24'h0, s.baud};
			`OFS_INTCTRL: n.readdata = {30'h0, s.intctrl};
			`OFS_WAKEINFO: n.readdata = {30'h0, s.power};
			default: n.readdata = 32'h0;
			endcase
		end
		// writable registers; status is read-only, kept in sleep
		if (wr) begin
			case (address)
			`OFS_CTRL_ONE: n.ctrl1 = {writedata[7:1], s.ctrl1[0]};
			`OFS_CTRL_TWO: n.ctrl2 = writedata[7:0];
			`OFS_CTRL_THREE: n.ctrl3 = writedata[7:0];
			`OFS_BAUD: n.baud = writedata[7:0];
			`OFS_INTCTRL: n.intctrl = writedata[1:0];
			default: n.ctrl1 = s.ctrl1;
			endcase
		end
		// status access then data read clears rx flags
		if (stat_acc)
			n.status_seen = 1'b1;
		if (data_rd && s.status_seen) begin
			n.rxif = 1'b0;
			n.oerr = 1'b0;
			n.ferr = 1'b0;
			n.perr = 1'b0;
			n.status_seen = 1'b0;
		end
		if (stat_acc && wr)
			n.txif = s.txif;
		// capture word with its flags; set beats clear
		if (data_ev) begin
			n.data = rx_word;
			n.ferr = stop_bad;
			n.perr = par_bad;
			n.rxif = 1'b1;
			if (s.ctrl1[`C1_NINE])
				n.ctrl1[`C1_RX8] = rx_word[8];
		end
		if (rx_overrun && active)
			n.oerr = 1'b1;
		if (tx_empty_event && active)
			n.txif = 1'b1;
		if (tx_idle_event && active)
			n.tidle = 1'b1;
		// wake-up sequencing
		wake_ok = s.ctrl2[`C2_WAKE] && s.ctrl1[`C1_MODE] &&
			s.ctrl1[`C1_ENABLE] && s.ctrl2[`C2_RXEN] &&
			s.ctrl2[`C2_RIE];
		n.pin_prev = serial_rx_tx_pin;
		fall = s.pin_prev && !serial_rx_tx_pin;
		n.wake_req = 1'b0;
		case (s.power)
		run_st: begin
			n.ignore = 1'b0;
			if (uart_clock_off)
				n.power = sleep_st;
		end
		sleep_st: begin
			if (fall && wake_ok) begin
				n.power = startup_st;
				n.wake_req = 1'b1;
				n.wake_pend = 1'b1;
				n.ignore = 1'b1;
				n.cnt = 24'h0;
			end else if (!uart_clock_off)
				n.power = run_st;
		end
		startup_st: begin
			n.cnt = s.cnt + 24'h1;
			if (s.cnt == 24'(STARTUP_CYCLES - 1)) begin
				n.power = run_st;
				n.ignore = 1'b0;
			end
		end
		default: n.power = run_st;
		endcase
		// combined interrupt, one low cycle for each cycle with any enabled event
		n.irq_n = 1'b1;
		if (s.intctrl[`IC_GLOBAL] && s.intctrl[`IC_SIM]) begin
			if ((tx_empty_event && s.ctrl2[`C2_TEIE] && active) ||
				(tx_idle_event && s.ctrl2[`C2_TIIE] && active) ||
				((rx_overrun && active) && s.ctrl2[`C2_RIE]) ||
				(data_ev && s.ctrl2[`C2_RIE] &&
				(!s.ctrl2[`C2_ADDEN] || top_bit)) || addr_ev)
				n.irq_n = 1'b0;
		end
		// wake interrupt only after start-up done
		if (s.wake_pend && s.power == run_st) begin
			n.wake_pend = 1'b0;
			if (s.intctrl[`IC_GLOBAL] && s.intctrl[`IC_SIM])
				n.irq_n = 1'b0;
		end
	end

	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '0;
			s.waitrequest <= 1'b1;
			s.irq_n <= 1'b1;
			s.pin_prev <= 1'b1;
			s.power <= run_st;
		end else begin
			s <= n;
		end
	end

	assign readdata     = s.readdata;
	assign waitrequest  = s.waitrequest;
	assign sim_irq_n    = s.irq_n;
	assign wake_request = s.wake_req;
	assign rx_ignore    = s.ignore;

	// framing flag follows stop bits of captured word
	ferr_capture_a: assert property (@(posedge clk) disable iff (rst)
		(rx_word_valid && !uart_clock_off && s.power == run_st && !s.ignore)
		|=> s.ferr == $past(stop_bad))
		else $error("framing flag not captured");
	// parity flag zero when checking off
	perr_gate_a: assert property (@(posedge clk) disable iff (rst)
		(data_ev && !s.ctrl1[`C1_PREN]) |=> !s.perr)
		else $error("parity flag set while disabled");
	// address mode suppresses low-top words
	addr_mask_a: assert property (@(posedge clk) disable iff (rst)
		(data_ev && s.ctrl2[`C2_ADDEN] && !top_bit && !s.wake_pend
		&& !(tx_empty_event || tx_idle_event || rx_overrun)) |=> s.irq_n)
		else $error("irq on data word in address mode");
	// masked module never interrupts
	irq_mask_a: assert property (@(posedge clk) disable iff (rst)
		!s.intctrl[`IC_SIM] |=> s.irq_n)
		else $error("irq while module disabled");
	// low held a second cycle only with a new cause in the cycle before
	irq_pulse_a: assert property (@(posedge clk) disable iff (rst)
		(!s.irq_n && !$past(s.irq_n)) |-> 1'b0 || $past(data_ev)
		|| $past(tx_empty_event) || $past(tx_idle_event)
		|| $past(rx_overrun) || $past(s.wake_pend))
		else $error("irq held without cause");
	// no capture while start-up runs
	startup_ignore_a: assert property (@(posedge clk) disable iff (rst)
		(s.power == startup_st && rx_word_valid) |=> !$changed(s.data))
		else $error("data taken during start-up");
	// wake edge leads to start-up
	wake_seq_a: assert property (@(posedge clk) disable iff (rst)
		(s.power == sleep_st && fall && wake_ok)
		|=> s.power == startup_st && s.wake_req)
		else $error("wake edge not taken");
	// receive flag never clears without data read
	flag_hold_a: assert property (@(posedge clk) disable iff (rst)
		(s.rxif && !data_rd) |=> s.rxif)
		else $error("flag cleared without data read");
endmodule // uart_rx_status
`default_nettype wire

// ===== tb/uart_far_node.sv
// far-side serial node: delivers received words and drives the pin
`timescale 1ns/10ps
`default_nettype none
module uart_far_node (
	input  wire logic       clk,
	output var  logic       rx_word_valid,
	output var  logic [8:0] rx_word,
	output var  logic       rx_stop1_bit,
	output var  logic       rx_stop2_bit,
	output var  logic       rx_parity_bit,
	output var  logic       serial_rx_tx_pin
);
	// idle line with pull-up, frame lines scrambled
	initial begin
		rx_word_valid = 1'b0;
		rx_word = 9'h1AA;
		{rx_stop1_bit, rx_stop2_bit, rx_parity_bit} = 3'h5;
		serial_rx_tx_pin = 1'b1;
	end
	// one word per call, lines inverted once the valid cycle is over
	task automatic send(input logic [8:0] w, input logic [2:0] sp);
		@(posedge clk);
		rx_word_valid <= 1'b1;
		rx_word <= w;
		{rx_stop1_bit, rx_stop2_bit, rx_parity_bit} <= sp;
		@(posedge clk);
		rx_word_valid <= 1'b0;
		rx_word <= ~w;
		{rx_stop1_bit, rx_stop2_bit, rx_parity_bit} <= ~sp;
	endtask
	// start bit edge on the line, then back to idle
	task automatic wake_edge();
		@(posedge clk);
		serial_rx_tx_pin <= 1'b0;
		repeat (3) @(posedge clk);
		serial_rx_tx_pin <= 1'b1;
	endtask
endmodule // uart_far_node
`default_nettype wire

// ===== tb/tb_uart_rx_status.sv
// self-checking bench for the rx status block
`timescale 1ns/10ps
`default_nettype none
`include "uart_rx_status_regs.svh"
module tb_uart_rx_status
	import uart_rx_status_pkg::*;
;
	logic        clk, rst, read, write, uart_clock_off;
	logic [3:0]  address;
	logic [31:0] writedata, readdata, q;
	logic        waitrequest, sim_irq_n, wake_request, rx_ignore;
	logic        vld, s1, s2, par, pin;
	logic [8:0]  word;
	logic [2:0]  evs;
	int          n_fail, checks_done, irq_cnt, wake_cnt, cyc, base;

	uart_rx_status #(.STARTUP_CYCLES(16)) i_uart_rx_status (
		.clk(clk), .rst(rst), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .rx_word_valid(vld), .rx_word(word),
		.rx_stop1_bit(s1), .rx_stop2_bit(s2), .rx_parity_bit(par),
		.rx_overrun(evs[2]), .tx_empty_event(evs[0]),
		.tx_idle_event(evs[1]), .uart_clock_off(uart_clock_off),
		.serial_rx_tx_pin(pin), .sim_irq_n(sim_irq_n),
		.wake_request(wake_request), .rx_ignore(rx_ignore));
	uart_far_node i_uart_far_node (.clk(clk), .rx_word_valid(vld),
		.rx_word(word), .rx_stop1_bit(s1), .rx_stop2_bit(s2),
		.rx_parity_bit(par), .serial_rx_tx_pin(pin));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// pulse counters and hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (sim_irq_n === 1'b0) irq_cnt <= irq_cnt + 1;
		if (wake_request === 1'b1) wake_cnt <= wake_cnt + 1;
		if (cyc == 20000) begin
			n_fail++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one avalon transfer, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		@(posedge clk);
		address <= a;
		writedata <= d;
		read <= ~w;
		write <= w;
		@(posedge clk);
		while (waitrequest !== 1'b0) @(posedge clk);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	// irq pulses since last look must lie in lo..hi
	task automatic ev(input int lo, input int hi);
		repeat (10) @(negedge clk);
		chk(32'(irq_cnt - base >= lo && irq_cnt - base <= hi), 32'h1);
		base = irq_cnt;
	endtask
	// word in, pulses counted, flags and data drained in order
	task automatic rx(input logic [8:0] w, input int n);
		i_uart_far_node.send(w, 3'h6);
		ev(n, n);
		rd(`OFS_STATUS, 32'h08);
		rd(`OFS_DATA, {24'h0, w[7:0]});
	endtask
	task automatic kick(input logic [2:0] m, input int n);
		@(posedge clk);
		evs <= m;
		@(posedge clk);
		evs <= 3'h0;
		ev(n, n);
	endtask

	// main sequence
	initial begin
		rst = 1'b1;
		{read, write, uart_clock_off, evs, address} = '0;
		writedata = 32'h0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rd(`OFS_STATUS, 32'h0);
		rd(`OFS_CTRL_ONE, 32'h0);
		wr(`OFS_CTRL_ONE, 32'hC0);
		wr(`OFS_CTRL_THREE, 32'h01);
		i_uart_far_node.send(9'h055, 3'h4);
		wr(`OFS_STATUS, 32'h0);
		rd(`OFS_STATUS, 32'h0A);
		rd(`OFS_DATA, 32'h55);
		rd(`OFS_STATUS, 32'h0);
		wr(`OFS_CTRL_THREE, 32'h0);
		i_uart_far_node.send(9'h003, 3'h7);
		rd(`OFS_STATUS, 32'h08);
		rd(`OFS_DATA, 32'h03);
		wr(`OFS_CTRL_ONE, 32'hD0);
		i_uart_far_node.send(9'h003, 3'h7);
		rd(`OFS_STATUS, 32'h09);
		rd(`OFS_DATA, 32'h03);
		wr(`OFS_CTRL_ONE, 32'hD8);
		i_uart_far_node.send(9'h003, 3'h3);
		rd(`OFS_STATUS, 32'h0A);
		rd(`OFS_DATA, 32'h03);
		// interrupt combining, parity off before address detect
		wr(`OFS_CTRL_ONE, 32'hC0);
		wr(`OFS_INTCTRL, 32'h3);
		wr(`OFS_CTRL_TWO, 32'h44);
		base = irq_cnt;
		rx(9'h001, 1);
		wr(`OFS_CTRL_TWO, 32'h54);
		rx(9'h001, 0);
		i_uart_far_node.send(9'h081, 3'h6);
		ev(1, 2);
		rd(`OFS_STATUS, 32'h08);
		rd(`OFS_DATA, 32'h81);
		wr(`OFS_INTCTRL, 32'h1);
		rx(9'h081, 0);
		wr(`OFS_INTCTRL, 32'h3);
		wr(`OFS_CTRL_TWO, 32'h01);
		kick(3'h1, 1);
		kick(3'h2, 0);
		kick(3'h4, 0);
		wr(`OFS_CTRL_TWO, 32'h46);
		kick(3'h2, 1);
		kick(3'h4, 1);
		// pin wake-up with the uart clock stopped
		wr(`OFS_CTRL_TWO, 32'h4C);
		base = irq_cnt;
		@(posedge clk);
		uart_clock_off <= 1'b1; // no transfer pending
		i_uart_far_node.wake_edge();
		uart_clock_off <= 1'b0;
		i_uart_far_node.send(9'h0AA, 3'h6);
		repeat (10) @(negedge clk);
		chk(32'(wake_cnt), 32'h1);
		chk({31'h0, rx_ignore}, 32'h1);
		chk(32'(irq_cnt - base), 32'h0);
		ev(1, 1);
		chk({31'h0, rx_ignore}, 32'h0);
		rd(`OFS_DATA, 32'h81);
		rd(`OFS_CTRL_TWO, 32'h4C);
		report_and_stop();
	end
endmodule // tb_uart_rx_status
`default_nettype wire
